// ===== hdl/epc_pkg.sv
// Purpose: shared constants and types for the exception priority controller
// Assumes: 32-bit apb register bus, 3-bit priority fields
// Notes: vector numbers double as exception numbers
package epc_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned EPC_NUM_IRQ = 44;
  localparam int unsigned EPC_NUM_EXC = 60;
  localparam int unsigned EPC_PRI_W = 3;
  localparam int unsigned EPC_RANK_W = 4;
  localparam int unsigned EPC_VEC_W = 6;
  localparam logic [43:0] EPC_IRQ_IMPL = 44'hCD8_F3FF_FFFF; // lines with a vector
  // ----------------------------------------
  // exception numbers
  // ----------------------------------------
  localparam logic [5:0] EPC_EXC_NONE = 6'h00;
  localparam logic [5:0] EPC_EXC_RESET = 6'h01;
  localparam logic [5:0] EPC_EXC_NMI = 6'h02;
  localparam logic [5:0] EPC_EXC_HARD = 6'h03;
  localparam logic [5:0] EPC_EXC_MEM = 6'h04;
  localparam logic [5:0] EPC_EXC_BUS = 6'h05;
  localparam logic [5:0] EPC_EXC_USAGE = 6'h06;
  localparam logic [5:0] EPC_EXC_SVC = 6'h0B;
  localparam logic [5:0] EPC_EXC_DEBUG = 6'h0C;
  localparam logic [5:0] EPC_EXC_PENDABLE_SERVICE_REQUEST = 6'h0E;
  localparam logic [5:0] EPC_EXC_TICK = 6'h0F;
  localparam logic [5:0] EPC_EXC_IRQ0 = 6'h10;
  // ranks: lower is more urgent; programmable value p ranks at p + 3
  localparam logic [3:0] EPC_RANK_RESET = 4'h0;
  localparam logic [3:0] EPC_RANK_NMI = 4'h1;
  localparam logic [3:0] EPC_RANK_HARD = 4'h2;
  localparam logic [3:0] EPC_RANK_PROG0 = 4'h3;
  localparam logic [3:0] EPC_RANK_IDLE = 4'hF;
  localparam logic [7:0] EPC_VEC_SP_OFS = 8'h00;
  localparam logic [7:0] EPC_VEC_RESET_OFS = 8'h04;
  localparam logic [2:0] EPC_PRI_RESET = 3'h0;
  // ----------------------------------------
  // register map (byte offsets)
  // ----------------------------------------
  localparam logic [11:0] EPC_REG_CTRL = 12'h000; // interrupt_control_state_reg
  localparam logic [11:0] EPC_REG_SHCTRL = 12'h004; // system_handler_control_reg
  localparam logic [11:0] EPC_REG_EN0 = 12'h010; // interrupt_set_enable_regs
  localparam logic [11:0] EPC_REG_EN1 = 12'h014;
  localparam logic [11:0] EPC_REG_INTERRUPT_DISABLE_REG = 12'h018; // interrupt_disable_reg
  localparam logic [11:0] EPC_REG_DIS1 = 12'h01C;
  localparam logic [11:0] EPC_REG_PEND0 = 12'h020; // software set-pending
  localparam logic [11:0] EPC_REG_PEND1 = 12'h024;
  localparam logic [11:0] EPC_REG_ACT0 = 12'h028; // active status, read only
  localparam logic [11:0] EPC_REG_ACT1 = 12'h02C;
  localparam logic [11:0] EPC_REG_SYSPRI = 12'h030; // system_handler_priority_regs
  localparam logic [11:0] EPC_REG_PRI = 12'h040; // irq_priority_regs base, 8 per word
  localparam logic [11:0] EPC_REG_PRI_END = 12'h054;
  // control register bits
  localparam int unsigned EPC_CTRL_NMI_SET = 31;
  localparam int unsigned EPC_CTRL_PENDABLE_SERVICE_REQUEST_SET = 28;
  localparam int unsigned EPC_CTRL_TICK_SET = 26;
  localparam int unsigned EPC_CTRL_DBG_EN = 24;
  localparam int unsigned EPC_CTRL_UNALIGN_TRP = 23;
  localparam int unsigned EPC_CTRL_DIV0_TRP = 22;
  // system handler control enables
  localparam int unsigned EPC_SH_MEM_EN = 16;
  localparam int unsigned EPC_SH_BUS_EN = 17;
  localparam int unsigned EPC_SH_USAGE_EN = 18;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } epc_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } epc_apb_rsp_t;
  typedef struct packed {
    logic mem_violation;
    logic xn_fetch;
    logic bus_precise;
    logic bus_imprecise;
    logic undef_instr;
    logic unaligned_illegal;
    logic unaligned_any;
    logic div_zero;
    logic bad_state;
    logic bad_return;
    logic svc_exec;
    logic debug_event;
    logic debug_halting;
    logic tick_zero;
    logic tick_int_en;
    logic nmi_pin;
    logic entry_error;
  } epc_core_evt_t;
  typedef struct packed {
    logic take;
    logic [5:0] vector;
    logic [7:0] vec_offset;
    logic tail_chain;
  } epc_take_t;
endpackage : epc_pkg

// ===== hdl/epc_controller.sv
// Purpose: exception state, arbitration and vector issue for the core
// Assumes: core acknowledges entry and return with one-cycle pulses
// Notes: apb slave answers with zero wait states
`timescale 1ns/10ps
module epc_controller (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // apb slave
  input wire epc_pkg::epc_apb_req_t apb_in,
  output epc_pkg::epc_apb_rsp_t apb_out,
  // event sources
  input wire logic [epc_pkg::EPC_NUM_IRQ-1:0] irq_line_in,
  input wire epc_pkg::epc_core_evt_t evt_in,
  // core handshake
  input wire logic core_entered_in,
  input wire logic core_return_in,
  output epc_pkg::epc_take_t take_out,
  output logic core_halt_out,
  output logic thread_mode_out,
  output logic [7:0] fetch_ofs_out,
  output logic unaligned_trap_out,
  output logic div0_trap_out
);
  import epc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {EPC_RUN, EPC_FETCH_SP, EPC_FETCH_PC} epc_boot_t;
  typedef struct packed {
    epc_boot_t boot;
    logic [EPC_NUM_EXC-1:0] pend;
    logic [EPC_NUM_EXC-1:0] act;
    logic [EPC_NUM_IRQ-1:0] en;
    logic [EPC_NUM_IRQ-1:0] line_q;
    logic [EPC_NUM_IRQ*EPC_PRI_W-1:0] irq_pri;
    logic [7*EPC_PRI_W-1:0] sys_pri;
    logic [2:0] sh_en;
    logic dbg_en;
    logic unalign_trp;
    logic div0_trp;
    logic [5:0] cur;
    epc_take_t take;
    epc_apb_rsp_t rsp;
  } epc_state_t;
  epc_state_t s;
  epc_state_t next_s;

  // ----------------------------------------
  // priority ranking
  // ----------------------------------------
  // index of each system handler in the sys_pri field
  function automatic int sys_slot(input int e);
    case (e)
      4: sys_slot = 0;
      5: sys_slot = 1;
      6: sys_slot = 2;
      11: sys_slot = 3;
      12: sys_slot = 4;
      14: sys_slot = 5;
      default: sys_slot = 6;
    endcase
  endfunction

  logic [EPC_RANK_W-1:0] rank [EPC_NUM_EXC];
  logic [EPC_NUM_EXC-1:0] enabled;
  genvar g;
  generate
    for (g = 0; g < EPC_NUM_EXC; g++) begin : g_rank
      if (g == 1) begin : g_rst
        assign rank[g] = EPC_RANK_RESET;
        assign enabled[g] = 1'b0;
      end else if (g == 2) begin : g_nmi
        assign rank[g] = EPC_RANK_NMI;
        assign enabled[g] = 1'b1;
      end else if (g == 3) begin : g_hard
        assign rank[g] = EPC_RANK_HARD;
        assign enabled[g] = 1'b1;
      end else if (g >= 16) begin : g_irq
        // lower value more urgent, offset past fixed ranks
        assign rank[g] = EPC_RANK_PROG0 + 4'(s.irq_pri[(g-16)*EPC_PRI_W +: EPC_PRI_W]);
        assign enabled[g] = s.en[g-16] & EPC_IRQ_IMPL[g-16];
      end else if (g inside {4, 5, 6, 11, 12, 14, 15}) begin : g_sys
        assign rank[g] = EPC_RANK_PROG0 + 4'(s.sys_pri[sys_slot(g)*EPC_PRI_W +: EPC_PRI_W]);
        if (g <= 6) begin : g_sh
          assign enabled[g] = s.sh_en[g-4];
        end else begin : g_on
          assign enabled[g] = 1'b1;
        end
      end else begin : g_none
        assign rank[g] = EPC_RANK_IDLE;
        assign enabled[g] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  logic [5:0] best;
  logic [EPC_RANK_W-1:0] best_rank;
  logic [EPC_RANK_W-1:0] cur_rank;
  // strict less-than on rank keeps the lowest number on a tie
  always_comb begin
    best = EPC_EXC_NONE;
    best_rank = EPC_RANK_IDLE;
    for (int i = 2; i < EPC_NUM_EXC; i++) begin
      if (s.pend[i] && enabled[i] && rank[i] < best_rank) begin
        best = 6'(i);
        best_rank = rank[i];
      end
    end
  end
  // running handler rank; thread mode ranks as idle
  always_comb begin
    cur_rank = EPC_RANK_IDLE;
    if (s.cur != EPC_EXC_NONE) begin
      cur_rank = rank[s.cur];
    end
  end

  // ----------------------------------------
  // synchronous fault causes
  // ----------------------------------------
  logic mem_req;
  logic bus_req;
  logic usage_req;
  logic bad_usage_cfg;
  logic esc_mem;
  logic esc_bus;
  logic esc_usage;
  logic dbg_req;
  assign mem_req = evt_in.mem_violation | evt_in.xn_fetch;
  assign bus_req = evt_in.bus_precise | evt_in.bus_imprecise;
  assign bad_usage_cfg = (evt_in.unaligned_any & s.unalign_trp) | (evt_in.div_zero & s.div0_trp);
  assign usage_req = evt_in.undef_instr | evt_in.unaligned_illegal | evt_in.bad_state |
                     evt_in.bad_return | bad_usage_cfg;
  // a disabled or not-urgent-enough fault cannot be handled: escalate, except an imprecise bus fault, which only pends
  assign esc_mem = mem_req & (~s.sh_en[0] | rank[EPC_EXC_MEM] >= cur_rank);
  assign esc_bus = evt_in.bus_precise & (~s.sh_en[1] | rank[EPC_EXC_BUS] >= cur_rank);
  assign esc_usage = usage_req & (~s.sh_en[2] | rank[EPC_EXC_USAGE] >= cur_rank);
  // debug monitor drops when halting, disabled, or outranked
  assign dbg_req = evt_in.debug_event & ~evt_in.debug_halting & s.dbg_en &
                   (rank[EPC_EXC_DEBUG] < cur_rank);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic pri_hit;
  logic [2:0] pri_word;
  assign wr = apb_in.psel & apb_in.penable & apb_in.pwrite;
  assign rd = apb_in.psel & apb_in.penable & ~apb_in.pwrite;
  assign pri_hit = apb_in.paddr >= EPC_REG_PRI && apb_in.paddr <= EPC_REG_PRI_END;
  assign pri_word = 3'((apb_in.paddr - EPC_REG_PRI) >> 2);

  // read mux; reserved bits read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (pri_hit) begin
      for (int k = 0; k < 8; k++) begin
        if (int'(pri_word) * 8 + k < EPC_NUM_IRQ) begin
          rdata[k*4 +: EPC_PRI_W] = s.irq_pri[(int'(pri_word)*8+k)*EPC_PRI_W +: EPC_PRI_W];
        end
      end
    end else begin
      case (apb_in.paddr)
        EPC_REG_CTRL: begin
          rdata[EPC_CTRL_NMI_SET] = s.pend[EPC_EXC_NMI];
          rdata[EPC_CTRL_PENDABLE_SERVICE_REQUEST_SET] = s.pend[EPC_EXC_PENDABLE_SERVICE_REQUEST];
          rdata[EPC_CTRL_TICK_SET] = s.pend[EPC_EXC_TICK];
          rdata[EPC_CTRL_DBG_EN] = s.dbg_en;
          rdata[EPC_CTRL_UNALIGN_TRP] = s.unalign_trp;
          rdata[EPC_CTRL_DIV0_TRP] = s.div0_trp;
          rdata[5:0] = s.cur;
        end
        EPC_REG_SHCTRL: rdata[EPC_SH_USAGE_EN:EPC_SH_MEM_EN] = s.sh_en;
        EPC_REG_EN0, EPC_REG_INTERRUPT_DISABLE_REG: rdata = s.en[31:0];
        EPC_REG_EN1, EPC_REG_DIS1: rdata[11:0] = s.en[43:32];
        EPC_REG_PEND0: rdata = s.pend[47:16];
        EPC_REG_PEND1: rdata[11:0] = s.pend[59:48];
        EPC_REG_ACT0: rdata = s.act[47:16];
        EPC_REG_ACT1: rdata[11:0] = s.act[59:48];
        EPC_REG_SYSPRI: rdata[20:0] = s.sys_pri;
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [EPC_NUM_EXC-1:0] set_p;
  always_comb begin
    next_s = s;
    set_p = '0;
    next_s.take.take = 1'b0;
    next_s.take.tail_chain = 1'b0;
    next_s.rsp.pready = 1'b1;
    next_s.rsp.pslverr = 1'b0;
    next_s.rsp.prdata = rd ? rdata : 32'h0000_0000;
    next_s.line_q = irq_line_in;
    // hardware request sources; reserved lines ignored
    set_p[EPC_NUM_EXC-1:16] = irq_line_in & EPC_IRQ_IMPL;
    set_p[EPC_EXC_NMI] = evt_in.nmi_pin;
    set_p[EPC_EXC_HARD] = evt_in.entry_error | esc_mem | esc_bus | esc_usage;
    set_p[EPC_EXC_MEM] = mem_req & ~esc_mem;
    set_p[EPC_EXC_BUS] = bus_req & ~esc_bus;
    set_p[EPC_EXC_USAGE] = usage_req & ~esc_usage;
    set_p[EPC_EXC_SVC] = evt_in.svc_exec;
    set_p[EPC_EXC_DEBUG] = dbg_req;
    set_p[EPC_EXC_TICK] = evt_in.tick_zero & evt_in.tick_int_en;
    // register writes
    if (wr) begin
      if (pri_hit) begin
        for (int k = 0; k < 8; k++) begin
          if (int'(pri_word) * 8 + k < EPC_NUM_IRQ) begin
            next_s.irq_pri[(int'(pri_word)*8+k)*EPC_PRI_W +: EPC_PRI_W] =
              apb_in.pwdata[k*4 +: EPC_PRI_W];
          end
        end
      end
      case (apb_in.paddr)
        EPC_REG_CTRL: begin
          set_p[EPC_EXC_NMI] = set_p[EPC_EXC_NMI] | apb_in.pwdata[EPC_CTRL_NMI_SET];
          set_p[EPC_EXC_PENDABLE_SERVICE_REQUEST] = apb_in.pwdata[EPC_CTRL_PENDABLE_SERVICE_REQUEST_SET];
          set_p[EPC_EXC_TICK] = set_p[EPC_EXC_TICK] | apb_in.pwdata[EPC_CTRL_TICK_SET];
          next_s.dbg_en = apb_in.pwdata[EPC_CTRL_DBG_EN];
          next_s.unalign_trp = apb_in.pwdata[EPC_CTRL_UNALIGN_TRP];
          next_s.div0_trp = apb_in.pwdata[EPC_CTRL_DIV0_TRP];
        end
        EPC_REG_SHCTRL: next_s.sh_en = apb_in.pwdata[EPC_SH_USAGE_EN:EPC_SH_MEM_EN];
        EPC_REG_EN0: next_s.en[31:0] = s.en[31:0] | apb_in.pwdata;
        EPC_REG_EN1: next_s.en[43:32] = s.en[43:32] | apb_in.pwdata[11:0];
        EPC_REG_INTERRUPT_DISABLE_REG: next_s.en[31:0] = s.en[31:0] & ~apb_in.pwdata;
        EPC_REG_DIS1: next_s.en[43:32] = s.en[43:32] & ~apb_in.pwdata[11:0];
        EPC_REG_PEND0: set_p[47:16] = set_p[47:16] | (apb_in.pwdata & EPC_IRQ_IMPL[31:0]);
        EPC_REG_PEND1: set_p[59:48] = set_p[59:48] | (apb_in.pwdata[11:0] & EPC_IRQ_IMPL[43:32]);
        EPC_REG_SYSPRI: next_s.sys_pri = apb_in.pwdata[20:0];
        default: ;
      endcase
    end
    // issue: only a strictly more urgent pending exception preempts
    // no issue in the entry cycle: pending of the entered vector is still set there
    // the take lands two cycles after the request (pend, then take), leaving room for one more instruction
    if (s.boot == EPC_RUN && best != EPC_EXC_NONE && best_rank < cur_rank && !s.take.take &&
        !core_entered_in) begin
      next_s.take.take = 1'b1;
      next_s.take.vector = best;
      next_s.take.vec_offset = {best, 2'b00};
      // a handler just finished: skip unstack and restack
      next_s.take.tail_chain = core_return_in;
    end
    // core took the vector: pending moves to active, the old one stays active
    if (core_entered_in) begin
      next_s.pend[s.take.vector] = 1'b0;
      next_s.act[s.take.vector] = 1'b1;
      next_s.cur = s.take.vector;
    end
    // return: retire current, fall back to the most urgent still active
    if (core_return_in && s.cur != EPC_EXC_NONE) begin
      next_s.act[s.cur] = 1'b0;
      next_s.cur = EPC_EXC_NONE;
      for (int i = EPC_NUM_EXC - 1; i >= 2; i--) begin
        if (s.act[i] && i != int'(s.cur) &&
            (next_s.cur == EPC_EXC_NONE || rank[i] <= rank[next_s.cur])) begin
          next_s.cur = 6'(i);
        end
      end
    end
    // new requests win over clearing; active-and-pending results
    next_s.pend = next_s.pend | set_p;
    // reset boot sequence: stack pointer then reset vector
    case (s.boot)
      EPC_FETCH_SP: begin
        next_s.boot = EPC_FETCH_PC;
      end
      EPC_FETCH_PC: begin
        next_s.boot = EPC_RUN;
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s <= '0;
      s.boot <= EPC_FETCH_SP;
      s.rsp.pready <= 1'b1;
      s.take.vector <= EPC_EXC_NONE;
    end else begin
      s <= next_s;
    end
  end

  // outputs; core halts during reset and the two vector fetches
  assign apb_out = s.rsp;
  assign take_out = s.take;
  assign core_halt_out = s.boot != EPC_RUN;
  assign thread_mode_out = s.cur == EPC_EXC_NONE;
  assign fetch_ofs_out = (s.boot == EPC_FETCH_SP) ? EPC_VEC_SP_OFS : EPC_VEC_RESET_OFS;
  assign unaligned_trap_out = s.unalign_trp;
  assign div0_trap_out = s.div0_trp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  pri_reset_a: assert property (@(posedge clock_in) $past(rst_in) |-> s.irq_pri == '0 && s.sys_pri == '0)
    else $error("priorities not zero after reset");
  boot_seq_a: assert property (@(posedge clock_in) disable iff (rst_in)
      $fell(rst_in) |-> fetch_ofs_out == EPC_VEC_SP_OFS ##1 fetch_ofs_out == EPC_VEC_RESET_OFS ##1 !core_halt_out)
    else $error("boot fetch order wrong");
  vec_ofs_a: assert property (@(posedge clock_in) disable iff (rst_in)
      take_out.take |-> take_out.vec_offset == {take_out.vector, 2'b00})
    else $error("vector offset mismatch");
  no_equal_pre_a: assert property (@(posedge clock_in) disable iff (rst_in)
      $rose(take_out.take) && !$past(thread_mode_out) |-> rank[take_out.vector] < $past(cur_rank))
    else $error("equal priority preempted");
  reserved_irq_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (s.pend[EPC_NUM_EXC-1:16] & ~EPC_IRQ_IMPL) == '0)
    else $error("reserved line pending");
  line_pend_a: assert property (@(posedge clock_in) disable iff (rst_in)
      irq_line_in[0] |=> s.pend[EPC_EXC_IRQ0])
    else $error("line request lost");
  nest_active_a: assert property (@(posedge clock_in) disable iff (rst_in)
      core_entered_in && !thread_mode_out && !core_return_in |=> s.act[$past(s.cur)] && !thread_mode_out)
    else $error("preempted handler lost active");
  svc_pend_a: assert property (@(posedge clock_in) disable iff (rst_in)
      evt_in.svc_exec |=> s.pend[EPC_EXC_SVC])
    else $error("svc not pended");
  nmi_pend_a: assert property (@(posedge clock_in) disable iff (rst_in)
      evt_in.nmi_pin |=> s.pend[EPC_EXC_NMI])
    else $error("nmi not pended");
  dbg_halt_a: assert property (@(posedge clock_in) disable iff (rst_in)
      evt_in.debug_halting && !$past(s.pend[EPC_EXC_DEBUG]) && !(wr) |=> !s.pend[EPC_EXC_DEBUG] || $past(s.pend[EPC_EXC_DEBUG]))
    else $error("debug monitor pended while halting");
endmodule // epc_controller

// ===== verification/epc_core_model.sv
// Purpose: behavioural core that accepts takes and returns from handlers
// Assumes: take_in is a one-cycle pulse, repeated until entered
// Notes: slow_in stretches entry to exercise repeated take pulses
`timescale 1ns/10ps
module epc_core_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // controller side
  input wire epc_pkg::epc_take_t take_in,
  output logic entered_out,
  output logic return_out,
  // bench control
  input wire logic slow_in,
  input wire logic ret_in
);
  logic [2:0] wait_cnt;
  // ----------------------------------------
  // entry and return
  // ----------------------------------------
  // repeated takes while waiting are ignored, as a busy core would
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wait_cnt <= 3'h0;
      entered_out <= 1'b0;
      return_out <= 1'b0;
    end else begin
      entered_out <= (wait_cnt == 3'h1);
      return_out <= ret_in;
      if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (take_in.take && !entered_out) begin
        wait_cnt <= slow_in ? 3'h4 : 3'h1;
      end
    end
  end
endmodule // epc_core_model

// ===== verification/tb.sv
// Purpose: self-checking bench for the exception priority controller
// Assumes: zero-wait apb, read data one cycle after the access edge
// Notes: outputs sampled on the falling edge, inputs driven on the rising
`timescale 1ns/10ps
module tb;
  import epc_pkg::*;
  logic clock_in, rst_in, slow, ret, entered, returned, halt, thread, trap_u, trap_d;
  logic [43:0] irq;
  logic [7:0] fofs;
  logic [31:0] rdq;
  epc_apb_req_t apb_in;
  epc_apb_rsp_t apb_out;
  epc_core_evt_t evt;
  epc_take_t take_out;
  int errors, tests_run;
  epc_controller i_epc_controller (.clock_in(clock_in), .rst_in(rst_in), .apb_in(apb_in), .apb_out(apb_out),
    .irq_line_in(irq), .evt_in(evt), .core_entered_in(entered), .core_return_in(returned),
    .take_out(take_out), .core_halt_out(halt), .thread_mode_out(thread), .fetch_ofs_out(fofs),
    .unaligned_trap_out(trap_u), .div0_trap_out(trap_d));
  epc_core_model i_epc_core_model (.clock_in(clock_in), .rst_in(rst_in), .take_in(take_out),
    .entered_out(entered), .return_out(returned), .slow_in(slow), .ret_in(ret));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    apb_in <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock_in);
    apb_in.penable <= 1'b1;
    do begin @(posedge clock_in); n++; end while (apb_out.pready !== 1'b1 && n < 64);
    if (n >= 64) errors++;
    apb_in <= '0;
    @(negedge clock_in);
    rdq = apb_out.prdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdq, e);
  endtask
  // bounded wait for a take, then for the core to enter it
  task automatic wait_take(input logic [5:0] v);
    int n;
    n = 0;
    do begin @(negedge clock_in); n++; end while (take_out.take !== 1'b1 && n < 300);
    if (n >= 300) errors++;
    chk({take_out.vector, take_out.vec_offset}, {v, v, 2'b00});
    n = 0;
    do begin @(negedge clock_in); n++; end while (entered !== 1'b1 && n < 300);
    if (n >= 300) errors++;
  endtask
  task automatic ret_pulse();
    @(posedge clock_in);
    ret <= 1'b1;
    @(posedge clock_in);
    ret <= 1'b0;
  endtask
  task automatic serve(input logic [5:0] v);
    wait_take(v);
    ret_pulse();
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    errors++;
    tally_and_finish();
  end
  initial begin
    int bits[3] = '{31, 28, 26};
    logic [5:0] vecs[3] = '{6'h02, 6'h0E, 6'h0F};
    {rst_in, slow, ret, irq, evt, apb_in} = '0;
    rst_in = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    @(negedge clock_in);
    chk({halt, fofs}, {1'b1, EPC_VEC_SP_OFS});
    @(negedge clock_in);
    chk({halt, fofs}, {1'b1, EPC_VEC_RESET_OFS});
    @(negedge clock_in);
    chk({halt, thread}, 2'b01);
    rd(EPC_REG_SYSPRI, 32'h0000_0000);
    rd(EPC_REG_PRI, 32'h0000_0000);
    rd(12'h100, 32'h0000_0000);
    apb(1'b1, EPC_REG_SYSPRI, 32'h001F_FFFF);
    rd(EPC_REG_SYSPRI, 32'h001F_FFFF);
    apb(1'b1, EPC_REG_SYSPRI, 32'h0000_0000);
    apb(1'b1, EPC_REG_SHCTRL, 32'h0007_0000);
    apb(1'b1, EPC_REG_EN0, 32'hFFFF_FFFF);
    apb(1'b1, EPC_REG_EN1, 32'h0000_0FFF);
    apb(1'b1, EPC_REG_CTRL, 32'h01C0_0000);
    chk({trap_u, trap_d}, 2'b11);
    // software raised system exceptions, one at a time from thread mode
    foreach (bits[i]) begin
      apb(1'b1, EPC_REG_CTRL, 32'h01C0_0000 | (32'h1 << bits[i]));
      serve(vecs[i]);
    end
    @(posedge clock_in);
    evt.svc_exec <= 1'b1;
    @(posedge clock_in);
    evt.svc_exec <= 1'b0;
    serve(EPC_EXC_SVC);
    // nesting with a slow core: irq0 priority 1, irq1 priority 0
    slow <= 1'b1;
    apb(1'b1, EPC_REG_PRI, 32'h0000_0001);
    @(posedge clock_in);
    irq <= 44'h003;
    @(posedge clock_in);
    irq <= '0;
    wait_take(6'h11);
    @(posedge clock_in);
    irq <= 44'h002;
    @(posedge clock_in);
    irq <= '0;
    apb(1'b1, EPC_REG_CTRL, 32'h81C0_0000);
    wait_take(EPC_EXC_NMI);
    rd(EPC_REG_ACT0, 32'h0000_0002);
    apb(1'b1, EPC_REG_INTERRUPT_DISABLE_REG, 32'h0000_0004);
    apb(1'b1, EPC_REG_PEND0, 32'h0400_001C);
    rd(EPC_REG_PEND0, 32'h0000_001F);
    ret_pulse();
    rd(EPC_REG_CTRL, 32'h01C0_0011);
    ret_pulse();
    serve(6'h11);
    serve(6'h13);
    serve(6'h14);
    serve(6'h10);
    apb(1'b1, EPC_REG_EN0, 32'h0000_0004);
    serve(6'h12);
    rd(EPC_REG_ACT0, 32'h0000_0000);
    tally_and_finish();
  end
endmodule // tb
